// ==== bench/lsp_master_model.sv ====
// serial bus master model framing transfers into the slave port
`timescale 1ns/10ps
module lsp_master_model
(
  output logic link_clk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out
);
  initial
  begin
    link_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // p is the idle clock level, so only modes 0/0 and 1/1 occur
  task automatic xfer(logic p, logic [31:0] f, int n,
    output logic [15:0] rx);
    link_clk = p;
    #3 chip_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      #40 link_clk = 1'b0;
      serial_in = f[i];
      #40 link_clk = 1'b1;
      rx = {rx[14:0], serial_out};
    end
    #40 link_clk = p;
    serial_in = 1'b0; // the model drives the data line low again after the last bit
    #40 chip_select_n = 1'b1;
  endtask
endmodule

// ==== bench/lsp_slave_monitor.sv ====
// assertion checker for the serial slave port
`timescale 1ns/10ps
module lsp_slave_monitor
  import lsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic hw_reset_n,
  input wire logic serial_out_oe,
  input wire logic wr_strobe,
  input wire logic [3:0] wr_addr,
  input wire logic [9:0] wr_data,
  input wire logic [9:0] interface_config_reg,
  input wire logic [9:0] general_config
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence cfg_wr; wr_strobe && wr_addr == CFG_ADDR; endsequence
  sequence gen_wr; wr_strobe && wr_addr != CFG_ADDR; endsequence
  AST_OE: assert property
    (serial_out_oe == !chip_select_n) else $error("bad enable");
  AST_PULSE: assert property
    (wr_strobe |=> !wr_strobe) else $error("long strobe");
  AST_EXEC: assert property
    (wr_strobe |-> chip_select_n) else $error("early write");
  AST_HWREJ: assert property
    (gen_wr |-> hw_reset_n) else $error("write in reset");
  AST_CLR: assert property
    (!hw_reset_n |-> general_config == GEN_RST) else $error("not cleared");
  AST_KEEP: assert property
    ($fell(hw_reset_n) |-> $stable(interface_config_reg)) else $error("lost");
  AST_CFG: assert property
    (cfg_wr |-> ##[0:2] interface_config_reg == wr_data) else $error("cfg");
  AST_GEN: assert property
    (gen_wr |-> ##[0:2] general_config == wr_data) else $error("gen");
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the serial slave port
`timescale 1ns/10ps
module tb;
  import lsp_pkg::*;
  typedef struct {logic [3:0] a; logic [9:0] d, g, c; logic h, e;} lsp_row_t;
  logic sys_clk, rst, link_clk, chip_select_n, serial_in, serial_out;
  logic serial_out_oe, hw_reset_n, wr_strobe, control_source_select;
  logic chain_mode_bit, frame_error, pe;
  logic [9:0] read_data, wr_data, interface_config_reg, general_config;
  logic [3:0] read_addr, wr_addr;
  logic [15:0] rx;
  int error_cnt = 0;
  int samples_checked = 0;
  lsp_row_t rows [4] = '{'{4'h3, 10'h3a5, 10'h3a5, 10'h000, 1'b1, 1'b0},
    '{4'hf, 10'h001, 10'h3a5, 10'h001, 1'b1, 1'b0},
    '{4'h3, 10'h155, 10'h000, 10'h001, 1'b0, 1'b1},
    '{4'hf, 10'h2c0, 10'h000, 10'h2c0, 1'b0, 1'b0}};
  lsp_slave i_lsp_slave (.*);
  lsp_master_model i_lsp_master_model (.*);
  function automatic logic [15:0] fr(logic w, logic [3:0] a, logic [9:0] d);
    return {w, a, ~^{w, a, d}, d};
  endfunction
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic run(logic p, logic [31:0] f, int n);
    @(posedge sys_clk);
    i_lsp_master_model.xfer(p, f, n, rx);
    repeat (20) @(posedge sys_clk);
    $display("test done");
  endtask
  task automatic tally_and_finish();
    $display("checked %0d wrong %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    rst = 1'b1;
    hw_reset_n = 1'b1;
    read_data = 10'h2b6;
    pe = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[k])
    begin
      hw_reset_n <= rows[k].h;
      run(0, fr(0, rows[k].a, rows[k].d), 16);
      chk("flag", rx[15], pe);
      chk("gen", general_config, rows[k].g);
      chk("icr", interface_config_reg, rows[k].c);
      chk("sel", control_source_select, rows[k].g[0]);
      chk("chain", chain_mode_bit, rows[k].c[0]);
      chk("err", frame_error, rows[k].e);
      pe = rows[k].e;
    end
    run(1, fr(1, 4'h5, 0), 16);
    chk("read", rx[9:0], read_data);
    chk("raddr", read_addr, 4'h5);
    chk("flag", rx[15], 0);
    hw_reset_n <= 1'b1;
    run(0, fr(0, 4'h3, 10'h0f0), 15);
    chk("err", frame_error, 1);
    run(0, fr(0, 4'h3, 10'h0f0) ^ 1, 16);
    chk("flag", rx[15], 1);
    chk("gen", general_config, 0);
    run(0, {fr(0, 4'h3, 10'h0aa), fr(0, 4'h3, 10'h0f0)}, 32);
    chk("gen", general_config, 10'h0f0);
    chk("err", frame_error, 0);
    chk("waddr", wr_addr, 4'h3);
    chk("wdata", wr_data, 10'h0f0);
    tally_and_finish();
  end
endmodule
bind lsp_slave lsp_slave_monitor i_lsp_slave_monitor (.*);

// ==== hw/lsp_slave.sv ====
// serial slave port of a dual channel led driver controller
`timescale 1ns/10ps
module lsp_slave
  import lsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic hw_reset_n,
  input wire logic [9:0] read_data,
  output logic [3:0] read_addr,
  output logic wr_strobe,
  output logic [3:0] wr_addr,
  output logic [9:0] wr_data,
  output logic [9:0] interface_config_reg,
  output logic [9:0] general_config,
  output logic control_source_select,
  output logic chain_mode_bit,
  output logic frame_error
);
  // link domain: shift in on rising edges, out on falling edges
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [15:0] rx_reg;
  logic [15:0] rx_next;
  logic [15:0] frame_reg;
  logic [15:0] tx_reg;
  logic [15:0] tx_next;
  logic [9:0] rd_hold_reg;
  logic seen_edge_reg;
  logic lead_done_reg;
  logic multiple_reg;
  logic start_tog_reg;
  logic count_end;
  logic addr_done;
  logic data_fetch;
  logic data_load;
  logic err_pending_reg;

  // address field decode, shared by every write path
  function automatic logic is_cfg_addr(input logic [15:0] f);
    return f[ADDR_HI:ADDR_LO] == CFG_ADDR;
  endfunction

  // bit count decode, shared by the capture points of the frame
  function automatic logic at_count(input logic [3:0] c,
    input logic [3:0] n);
    return c == n;
  endfunction

  assign rx_next = {rx_reg[14:0], serial_in};
  assign bit_cnt_next = bit_cnt_reg + 4'h1;
  assign count_end = at_count(bit_cnt_reg, 4'hf);
  assign addr_done = at_count(bit_cnt_reg, 4'h4);
  assign data_fetch = at_count(bit_cnt_reg, 4'h5);
  assign data_load = at_count(bit_cnt_reg, 4'h6);

  // select high resets the link side, since the clock may stand still
  // between frames and cannot be relied on to clear anything
  always_ff @(posedge link_clk or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      bit_cnt_reg <= BIT_CNT_RST;
      rx_reg <= SHIFT_RST;
      seen_edge_reg <= 1'b0;
    end
    else
    begin
      seen_edge_reg <= 1'b1;
      rx_reg <= rx_next;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // these survive the select rise, so the system side can read them
  // after select settles high without racing the link side clear
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      multiple_reg <= 1'b0;
      start_tog_reg <= 1'b0;
    end
    else if (!chip_select_n)
    begin
      multiple_reg <= count_end;
      if (!seen_edge_reg)
        start_tog_reg <= ~start_tog_reg;
    end
  end

  // last complete sixteen bits; earlier frames of a long burst are lost
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      frame_reg <= SHIFT_RST;
    else if (!chip_select_n && count_end)
      frame_reg <= rx_next;
  end

  // address is complete after the fifth rising edge
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      read_addr <= 4'h0;
    else if (!chip_select_n && addr_done)
      read_addr <= rx_next[3:0];
  end

  // the outside world has one link period to answer the address
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      rd_hold_reg <= CFG_RST;
    else if (!chip_select_n && data_fetch)
      rd_hold_reg <= read_data;
  end

  always_comb
  begin
    if (data_load)
      tx_next = {rd_hold_reg, 6'h00};
    else
      tx_next = {tx_reg[14:0], 1'b0};
  end

  // falling edges before the first rising one are ignored, which is what
  // lets modes 0/0 and 1/1 share one shifter
  always_ff @(negedge link_clk or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      tx_reg <= SHIFT_RST;
      lead_done_reg <= 1'b0;
    end
    else if (seen_edge_reg)
    begin
      lead_done_reg <= 1'b1;
      tx_reg <= tx_next;
    end
  end

  // the error flag leads until the first falling edge after a rising one; it only changes
  // while select is high, a few system cycles after the rise
  assign serial_out = lead_done_reg ? tx_reg[15] : err_pending_reg;
  assign serial_out_oe = ~chip_select_n;

  // system domain: select and reset pin pass three flops each
  logic [2:0] cs_sync_reg;
  logic [2:0] hr_sync_reg;
  logic hr_ok_reg;
  lsp_state_t state_reg;
  lsp_state_t state_next;
  logic last_tog_reg;
  logic exec;
  logic fresh;
  logic qualified;
  logic is_write;
  logic to_cfg;
  logic wr_allowed;
  logic wr_go;
  logic [9:0] cfg_next;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cs_sync_reg <= 3'h7;
    else
      cs_sync_reg <= {cs_sync_reg[1:0], chip_select_n};
  end

  // reset pin is idle high after a system reset, so no false entry
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hr_sync_reg <= 3'h7;
      hr_ok_reg <= 1'b1;
    end
    else
    begin
      hr_sync_reg <= {hr_sync_reg[1:0], hw_reset_n};
      if (hr_sync_reg[2] == hr_sync_reg[1])
        hr_ok_reg <= hr_sync_reg[2];
    end
  end

  // frame tracking: idle, selected, then one execute cycle
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      LSP_IDLE:
        if (!cs_sync_reg[2] && !cs_sync_reg[1])
          state_next = LSP_SHIFT;
      LSP_SHIFT:
        if (cs_sync_reg[2] && cs_sync_reg[1])
          state_next = LSP_DONE;
      LSP_DONE:
        state_next = LSP_IDLE;
      default:
        state_next = LSP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state_reg <= LSP_IDLE;
    else
      state_reg <= state_next;
  end

  // each select period with a rising link edge flips the toggle once, so an empty select pulse cannot
  // execute the previous frame a second time
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      last_tog_reg <= 1'b0;
    else if (exec)
      last_tog_reg <= start_tog_reg;
  end

  assign exec = (state_reg == LSP_DONE);
  assign fresh = (start_tog_reg != last_tog_reg);
  assign qualified = multiple_reg && fresh && lsp_parity_ok(frame_reg);
  assign is_write = !frame_reg[DIR_POS];
  assign to_cfg = is_cfg_addr(frame_reg);
  assign wr_allowed = hr_ok_reg || to_cfg;
  assign wr_go = exec && qualified && is_write && wr_allowed;

  always_comb
  begin
    cfg_next = frame_reg[DATA_HI:0];
  end

  // interface config is outside the pin reset
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      interface_config_reg <= CFG_RST;
    else if (wr_go && to_cfg)
      interface_config_reg <= cfg_next;
  end

  // chain mode is only reported; standard behaviour applies either way
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      chain_mode_bit <= 1'b0;
    else
      chain_mode_bit <= interface_config_reg[CFG_CHAIN_BIT];
  end

  // the pin clears the rest asynchronously and holds it while low
  always_ff @(posedge sys_clk or negedge hw_reset_n or posedge rst)
  begin
    if (rst)
      general_config <= GEN_RST;
    else if (!hw_reset_n)
      general_config <= GEN_RST;
    else if (wr_go && !to_cfg)
      general_config <= cfg_next;
  end

  // the control source follows the select bit, so it returns to the
  // registers only once software writes it after a reset
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      control_source_select <= 1'b0;
    else
      control_source_select <= general_config[SEL_BIT];
  end

  // rejected frames and non-config writes under reset raise the error flag, which
  // the next frame shifts out first
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      err_pending_reg <= 1'b0;
    else if (exec)
      err_pending_reg <= !qualified
        || (is_write && !wr_allowed);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wr_strobe <= 1'b0;
    else
      wr_strobe <= wr_go;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_addr <= 4'h0;
      wr_data <= 10'h000;
    end
    else
    begin
      wr_addr <= frame_reg[ADDR_HI:ADDR_LO];
      wr_data <= cfg_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      frame_error <= 1'b0;
    else
      frame_error <= err_pending_reg;
  end
endmodule

// ==== pkg/lsp_pkg.sv ====
// constants and types for the led driver serial slave port
package lsp_pkg;
  localparam int FRAME_BITS = 16;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic [3:0] CFG_ADDR = 4'hf;
  localparam logic [9:0] CFG_RST = 10'h000;
  localparam logic [9:0] GEN_RST = 10'h000;
  localparam int CFG_CHAIN_BIT = 0;
  localparam int SEL_BIT = 0;
  localparam int DIR_POS = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 11;
  localparam int PAR_POS = 10;
  localparam int DATA_HI = 9;
  typedef enum logic [1:0] {
    LSP_IDLE = 2'b00,
    LSP_SHIFT = 2'b01,
    LSP_DONE = 2'b11
  } lsp_state_t;
  // odd parity over the whole frame
  function automatic logic lsp_parity_ok(input logic [15:0] f);
    return ^f;
  endfunction
endpackage
